// ==== rtl/opv_pkg.sv ====
// Package for the one-time-programmable program and verify port.
package opv_pkg;
  // Memory geometry.
  localparam int OPV_ADDR_W = 13;
  localparam int OPV_MEM_WORDS = 8192;
  localparam int OPV_KEY_WORDS = 32;
  localparam int OPV_KEY_IDX_W = 5;
  // Pulses needed to program one location.
  localparam logic [4:0] OPV_PULSES = 5'h19;
  // Signature locations and neutral signature values (values arbitrary).
  localparam logic [OPV_ADDR_W-1:0] OPV_SIG_MFR_ADDR = 13'h0030;
  localparam logic [OPV_ADDR_W-1:0] OPV_SIG_PART_ADDR = 13'h0031;
  localparam logic [7:0] OPV_SIG_MFR_VAL = 8'h5a;
  localparam logic [7:0] OPV_SIG_PART_VAL = 8'ha5;
  // Mode codes from port 2 bits 7,6 and port 3 bits 7,6.
  localparam logic [3:0] OPV_CODE_PROG = 4'hb;
  localparam logic [3:0] OPV_CODE_KEY = 4'ha;
  localparam logic [3:0] OPV_CODE_LOCK1 = 4'hf;
  localparam logic [3:0] OPV_CODE_LOCK2 = 4'hc;
  localparam logic [3:0] OPV_CODE_VERIFY = 4'h3;
  localparam logic [3:0] OPV_CODE_SIG = 4'h0;
  // Erased byte value of the memory.
  localparam logic [7:0] OPV_ERASED = 8'hff;

  // Decoded access mode, one-hot.
  typedef enum logic [6:0] {
    OPV_M_IDLE = 7'b000_0001,
    OPV_M_PROG = 7'b000_0010,
    OPV_M_KEY = 7'b000_0100,
    OPV_M_LOCK1 = 7'b000_1000,
    OPV_M_LOCK2 = 7'b001_0000,
    OPV_M_VERIFY = 7'b010_0000,
    OPV_M_SIG = 7'b100_0000
  } opv_mode_t;

  // Pin group presented by the programmer.
  typedef struct packed {
    logic reset_pin;
    logic program_store_strobe_n;
    logic latch_program_strobe;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } opv_pins_t;

  // Registered state of the block.
  typedef struct packed {
    logic strobe_q;
    logic [4:0] pulses;
    logic [OPV_ADDR_W-1:0] addr_q;
    logic key_done;
    logic lock1;
    logic lock2;
    logic [7:0] p0_out;
    logic p0_oe;
  } opv_state_t;
endpackage

// ==== rtl/opv_port.sv ====
// Program and verify access port of the on-chip one-time-programmable memory.
// What this block does
// - Mode from port bits under reset, strobe low.
// - Verified data XNORed with key once loaded.
// - Key table never read out directly.
// - Any lock bit blocks code and key writes.
// - Remaining lock bit stays programmable.
// - Verify allowed only while lock two clear.
// - Verify drives addressed byte on port 0.
// - Two signature bytes are held.
// - Signatures at 30 and 31, port 3 low.
`timescale 1ns/1ps
module opv_port
  import opv_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Programming pins.
  input wire opv_pins_t pins,
  // Port 0 drive back to the programmer.
  output logic [7:0] p0_out,
  output logic p0_oe,
  // Lock status.
  output logic lock1_set,
  output logic lock2_set
);

  opv_state_t st;
  opv_state_t next_st;
  opv_mode_t mode;
  // Arrays power up erased; reset leaves their cells alone.
  logic [7:0] code_mem [OPV_MEM_WORDS] = '{default: OPV_ERASED};
  logic [7:0] key_mem [OPV_KEY_WORDS] = '{default: OPV_ERASED};
  logic [OPV_ADDR_W-1:0] addr;
  logic fall;
  logic done;
  logic [7:0] rd_code;
  logic [7:0] rd_key;

  // Decodes the access mode from the four strap bits.
  function automatic opv_mode_t opv_decode(input opv_pins_t p);
    logic [3:0] c;
    c = {p.p2[7], p.p2[6], p.p3[7], p.p3[6]};
    if (!p.reset_pin || p.program_store_strobe_n) begin
      return OPV_M_IDLE;
    end
    case (c)
      OPV_CODE_PROG: return OPV_M_PROG;
      OPV_CODE_KEY: return OPV_M_KEY;
      OPV_CODE_LOCK1: return OPV_M_LOCK1;
      OPV_CODE_LOCK2: return OPV_M_LOCK2;
      OPV_CODE_VERIFY: return OPV_M_VERIFY;
      OPV_CODE_SIG: return OPV_M_SIG;
      default: return OPV_M_IDLE;
    endcase
  endfunction

  // Mode, address and pulse completion.
  always_comb begin
    mode = opv_decode(pins);
    addr = {pins.p2[4:0], pins.p1};
    fall = st.strobe_q && !pins.latch_program_strobe;
    done = fall && (st.pulses == OPV_PULSES - 5'h01);
  end

  // Memory reads; the key table is only seen through the XNOR.
  always_comb begin
    rd_code = code_mem[addr];
    rd_key = key_mem[addr[OPV_KEY_IDX_W-1:0]];
  end

  // Next state of pulse counter, locks and port 0 drive.
  always_comb begin
    next_st = st;
    next_st.strobe_q = pins.latch_program_strobe;
    next_st.addr_q = addr;
    next_st.p0_oe = 1'b0;
    next_st.p0_out = 8'h00;
    case (mode)
      OPV_M_PROG, OPV_M_KEY, OPV_M_LOCK1, OPV_M_LOCK2: begin
        if (addr != st.addr_q) begin
          next_st.pulses = 5'h00;
        end else if (done) begin
          next_st.pulses = 5'h00;
        end else if (fall) begin
          next_st.pulses = st.pulses + 5'h01;
        end
        if (done && mode == OPV_M_KEY && !(st.lock1 || st.lock2)) begin
          next_st.key_done = 1'b1;
        end
        if (done && mode == OPV_M_LOCK1) begin
          next_st.lock1 = 1'b1;
        end
        if (done && mode == OPV_M_LOCK2) begin
          next_st.lock2 = 1'b1;
        end
      end
      OPV_M_VERIFY: begin
        next_st.pulses = 5'h00;
        if (!st.lock2) begin
          next_st.p0_oe = 1'b1;
          next_st.p0_out = st.key_done ? ~(rd_code ^ rd_key) : rd_code;
        end
      end
      OPV_M_SIG: begin
        next_st.pulses = 5'h00;
        if (addr == OPV_SIG_MFR_ADDR) begin
          next_st.p0_oe = 1'b1;
          next_st.p0_out = OPV_SIG_MFR_VAL;
        end else if (addr == OPV_SIG_PART_ADDR) begin
          next_st.p0_oe = 1'b1;
          next_st.p0_out = OPV_SIG_PART_VAL;
        end
      end
      OPV_M_IDLE: begin
        next_st.pulses = 5'h00;
      end
      default: begin
        next_st.pulses = 5'h00;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Array writes after the 25th pulse, blocked once any lock is set.
  always_ff @(posedge clk_sys) begin
    if (done && !(st.lock1 || st.lock2)) begin
      if (mode == OPV_M_PROG) begin
        code_mem[addr] <= code_mem[addr] & pins.p0;
      end
      if (mode == OPV_M_KEY) begin
        key_mem[addr[OPV_KEY_IDX_W-1:0]] <= pins.p0;
      end
    end
  end

  // Outputs straight from the state register.
  assign p0_out = st.p0_out;
  assign p0_oe = st.p0_oe;
  assign lock1_set = st.lock1;
  assign lock2_set = st.lock2;

  // Checks on locks, port 0 drive and the pulse counter.
  a_lock_blocks_key: assert property (@(posedge clk_sys)
    disable iff (rst)
    (st.lock1 || st.lock2) && !st.key_done |=> !st.key_done)
    else $error("key table written while locked");
  a_verify_gated: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_VERIFY && st.lock2 |=> !p0_oe)
    else $error("verify drove port 0 with lock two set");
  a_verify_drives: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_VERIFY && !st.lock2 |=> p0_oe)
    else $error("verify did not drive port 0");
  a_sig_mfr_value: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_SIG && addr == OPV_SIG_MFR_ADDR
    |=> p0_oe && p0_out == OPV_SIG_MFR_VAL)
    else $error("wrong manufacturer signature");
  a_sig_part_value: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_SIG && addr == OPV_SIG_PART_ADDR
    |=> p0_oe && p0_out == OPV_SIG_PART_VAL)
    else $error("wrong part signature");
  a_lock1_after_pulses: assert property (@(posedge clk_sys)
    disable iff (rst)
    done && mode == OPV_M_LOCK1 |=> lock1_set)
    else $error("lock one not set after pulses");
  a_pulse_count_step: assert property (@(posedge clk_sys)
    disable iff (rst)
    fall && !done && mode == OPV_M_PROG && addr == st.addr_q
    |=> st.pulses == $past(st.pulses) + 5'h01)
    else $error("pulse count did not step");
  a_pulse_limit: assert property (@(posedge clk_sys)
    disable iff (rst)
    st.pulses < OPV_PULSES)
    else $error("pulse count passed its limit");
  a_idle_no_drive: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_IDLE |=> !p0_oe)
    else $error("port 0 driven outside access modes");

  // A verify cycle followed by one more on the same address.
  sequence s_verify_repeat;
    mode == OPV_M_VERIFY && !st.lock2
    ##1 mode == OPV_M_VERIFY && addr == st.addr_q;
  endsequence

  // Read data must stand while the programmer holds the verify levels.
  a_verify_stands: assert property (@(posedge clk_sys)
    disable iff (rst)
    s_verify_repeat |=> p0_oe && $stable(p0_out))
    else $error("verify data did not stand");
  a_sig_other_quiet: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_SIG && addr != OPV_SIG_MFR_ADDR
    && addr != OPV_SIG_PART_ADDR |=> !p0_oe)
    else $error("signature mode drove port 0 off its two locations");
  a_read_no_count: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_VERIFY || mode == OPV_M_SIG |=> st.pulses == 5'h00)
    else $error("strobe counted in a read mode");
  a_addr_move_clears: assert property (@(posedge clk_sys)
    disable iff (rst)
    mode == OPV_M_PROG && addr != st.addr_q |=> st.pulses == 5'h00)
    else $error("pulse count kept across an address change");
  a_lock2_after_pulses: assert property (@(posedge clk_sys)
    disable iff (rst)
    done && mode == OPV_M_LOCK2 |=> lock2_set)
    else $error("lock two not set after pulses");
  a_lock1_sticky: assert property (@(posedge clk_sys)
    disable iff (rst)
    lock1_set |=> lock1_set)
    else $error("lock one cleared without reset");
  a_lock2_sticky: assert property (@(posedge clk_sys)
    disable iff (rst)
    lock2_set |=> lock2_set)
    else $error("lock two cleared without reset");
  a_key_done_set: assert property (@(posedge clk_sys)
    disable iff (rst)
    done && mode == OPV_M_KEY && !(st.lock1 || st.lock2) |=> st.key_done)
    else $error("key table load not recorded");
endmodule

// ==== testbench/opv_prog_model.sv ====
// Programmer model that drives the port pins of the memory block.
`timescale 1ns/1ps
module opv_prog_model
  import opv_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Port 0 drive from the device.
  input wire logic [7:0] p0_out,
  input wire logic p0_oe,
  // Pins to the device.
  output opv_pins_t pins
);
  logic [3:0] code;
  logic [12:0] addr;
  logic [7:0] p0_drv;
  logic p0_en;
  logic strobe;
  logic store_n;

  // Mode bits, address and pulled-up port 0 form the pin group.
  assign pins = '{reset_pin: 1'b1, program_store_strobe_n: store_n,
    latch_program_strobe: strobe, p1: addr[7:0],
    p2: {code[3:2], 1'b0, addr[12:8]}, p3: {code[1:0], 6'h00},
    p0: p0_oe ? p0_out : (p0_en ? p0_drv : 8'hff)};

  // Idle levels at time zero.
  initial begin
    code = 4'h0;
    addr = 13'h0000;
    p0_drv = 8'h00;
    p0_en = 1'b0;
    strobe = 1'b1;
    store_n = 1'b0;
  end

  // Sets mode, address and data; only program modes drive port 0.
  task automatic setup(input logic [3:0] c, input logic [12:0] a,
                       input logic [7:0] d);
    @(posedge clk_sys);
    code <= c;
    addr <= a;
    p0_drv <= d;
    p0_en <= c[3];
    strobe <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  // Pulse widths are shrunk to one cycle low and one high.
  task automatic pulse_all;
    pulse_some(int'(OPV_PULSES));
  endtask

  // Gives a chosen count of pulses, one cycle low and one high each.
  task automatic pulse_some(input int n);
    repeat (n) begin
      strobe <= 1'b0;
      @(posedge clk_sys);
      strobe <= 1'b1;
      @(posedge clk_sys);
    end
  endtask

  // Moves the program-store strobe, then lets two edges pass.
  task automatic set_store_n(input logic s);
    @(posedge clk_sys);
    store_n <= s;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

// ==== testbench/tb_otp_program_verify_port.sv ====
// Self-checking bench for the program and verify port.
`timescale 1ns/1ps
module tb_otp_program_verify_port;
  import opv_pkg::*;
  logic clk_sys;
  logic rst;
  opv_pins_t pins;
  logic [7:0] p0_out;
  logic p0_oe;
  logic lock1_set;
  logic lock2_set;
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] mem [8192];
  logic [7:0] key [32];
  logic key_done = 1'b0;
  logic lk1 = 1'b0;
  logic lk2 = 1'b0;

  opv_port i_opv_port (.clk_sys(clk_sys), .rst(rst), .pins(pins),
    .p0_out(p0_out), .p0_oe(p0_oe), .lock1_set(lock1_set),
    .lock2_set(lock2_set));
  opv_prog_model i_opv_prog_model (.clk_sys(clk_sys), .p0_out(p0_out),
    .p0_oe(p0_oe), .pins(pins));

  // Counts a comparison and reports a difference.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Programs one location and updates the reference model.
  task automatic write(input logic [3:0] c, input logic [12:0] a,
                       input logic [7:0] d);
    i_opv_prog_model.setup(c, a, d);
    i_opv_prog_model.pulse_all();
    repeat (3) @(posedge clk_sys);
    if (c == OPV_CODE_PROG && !lk1 && !lk2) begin
      mem[a] = mem[a] & d;
    end
    if (c == OPV_CODE_KEY && !lk1 && !lk2) begin
      key[a[4:0]] = d;
      key_done = 1'b1;
    end
    lk1 = lk1 | (c == OPV_CODE_LOCK1);
    lk2 = lk2 | (c == OPV_CODE_LOCK2);
    check(8'(lock1_set), 8'(lk1));
    check(8'(lock2_set), 8'(lk2));
  endtask

  // Reads one location in a read mode and compares with the model.
  task automatic read(input logic [3:0] c, input logic [12:0] a);
    logic [7:0] exp;
    logic oe;
    i_opv_prog_model.setup(c, a, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    oe = (c == OPV_CODE_SIG) ? (a == 13'h0030 || a == 13'h0031) : !lk2;
    exp = key_done ? ~(mem[a] ^ key[a[4:0]]) : mem[a];
    if (c == OPV_CODE_SIG) begin
      exp = a[0] ? OPV_SIG_PART_VAL : OPV_SIG_MFR_VAL;
    end
    check(8'(p0_oe), 8'(oe));
    if (oe) check(p0_out, exp);
  endtask

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cuts a hang short.
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end

  // Main sequence.
  initial begin : main
    logic [12:0] a;
    rst = 1'b1;
    void'($urandom(32'ha3c9_60e6));
    for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
    for (int i = 0; i < 32; i++) key[i] = 8'hff;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) read(OPV_CODE_SIG, 13'h0030 + 13'(i));
    for (int i = 0; i < 6; i++) begin
      a = 13'($urandom_range(32'h0000_1fff));
      write(OPV_CODE_PROG, a, 8'($urandom));
      write(OPV_CODE_PROG, a, 8'($urandom));
      read(OPV_CODE_VERIFY, a);
    end
    i_opv_prog_model.setup(OPV_CODE_VERIFY, a, 8'h00);
    i_opv_prog_model.pulse_all();
    read(OPV_CODE_VERIFY, a);
    i_opv_prog_model.setup(OPV_CODE_PROG, a, 8'h00);
    i_opv_prog_model.pulse_some(int'(OPV_PULSES) - 1);
    read(OPV_CODE_VERIFY, a);
    i_opv_prog_model.set_store_n(1'b1);
    #1;
    check(8'(p0_oe), 8'h00);
    i_opv_prog_model.set_store_n(1'b0);
    i_opv_prog_model.setup(4'h5, a, 8'h00);
    #1;
    check(8'(p0_oe), 8'h00);
    for (int i = 0; i < 32; i++) write(OPV_CODE_KEY, 13'(i), 8'($urandom));
    read(OPV_CODE_VERIFY, a);
    for (int i = 0; i < 40; i++) read(OPV_CODE_VERIFY, 13'($urandom));
    write(OPV_CODE_LOCK1, 13'h0000, 8'h00);
    write(OPV_CODE_PROG, a, 8'h00);
    write(OPV_CODE_KEY, 13'h0003, 8'h00);
    read(OPV_CODE_VERIFY, a);
    read(OPV_CODE_VERIFY, 13'h0003);
    write(OPV_CODE_LOCK2, 13'h0000, 8'h00);
    read(OPV_CODE_VERIFY, a);
    print_verdict();
  end
endmodule
